// file: rtl/tcc_defs.vh
// register map, field positions and reset values of the capture/compare timer
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// ---------------------------------------------------------------
// register offsets (byte address = channel * stride + offset)
// ---------------------------------------------------------------
`define TCC_CH_STRIDE     8'h20
`define TCC_OFS_CTRL      8'h00
`define TCC_OFS_PINCTL    8'h04
`define TCC_OFS_CNT       8'h08
`define TCC_OFS_GRA       8'h0C
`define TCC_OFS_GRB       8'h10
`define TCC_OFS_FLAGS     8'h14
`define TCC_OFS_START     8'h60

// ---------------------------------------------------------------
// channel_control fields
// ---------------------------------------------------------------
`define TCC_CS_LSB        0
`define TCC_EDGE_LOW      3
`define TCC_EDGE_HIGH     4
`define TCC_CLR_LSB       5
`define TCC_PWM_BIT       7
`define TCC_SYNC_BIT      8
`define TCC_PHASE_BIT     9
`define TCC_CTRL_W        10

// ---------------------------------------------------------------
// clear select codes
// ---------------------------------------------------------------
`define TCC_CLR_NONE      2'h0
`define TCC_CLR_ON_A      2'h1
`define TCC_CLR_ON_B      2'h2
`define TCC_CLR_SYNC      2'h3

// ---------------------------------------------------------------
// pin_function_control codes, one 3-bit field per pin
// ---------------------------------------------------------------
`define TCC_PIN_B_LSB     4
`define TCC_IO_NONE       3'h0
`define TCC_IO_OUT0       3'h1
`define TCC_IO_OUT1       3'h2
`define TCC_IO_TOGGLE     3'h3

// ---------------------------------------------------------------
// flag bits, reset values, counter limits
// ---------------------------------------------------------------
`define TCC_FLAG_MA       0
`define TCC_FLAG_MB       1
`define TCC_FLAG_OVF      2
`define TCC_CTRL_RST      10'h000
`define TCC_PINCTL_RST    7'h00
`define TCC_GR_RST        16'hFFFF
`define TCC_CNT_MAX       16'hFFFF
`define TCC_CNT_ZERO      16'h0000

`endif

// file: rtl/tcc_edge.v
// edge detector for synchronous input pins
`timescale 1ns/100ps
`default_nettype none
module tcc_edge #(
    parameter W = 4
) (
    input  wire         CLK,   // system clock
    input  wire         NRST,  // async reset, active low
    input  wire [W-1:0] PIN,   // sampled pins
    output wire [W-1:0] RISE,  // rising edge this cycle
    output wire [W-1:0] FALL,  // falling edge this cycle
    output wire [W-1:0] LVL    // level before the edge
);
    reg [W-1:0] prev;  // previous sample

    // ---------------------------------------------------------------
    // history register
    // ---------------------------------------------------------------
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            prev <= {W{1'b0}};
        end else begin
            prev <= PIN;
        end
    end

    assign RISE = PIN & ~prev;
    assign FALL = ~PIN & prev;
    assign LVL  = prev;
endmodule // tcc_edge
`default_nettype wire

// file: rtl/tcc_prescale.v
// free-running prescaler giving system clock, /2, /4 and /8 count ticks
`timescale 1ns/100ps
`default_nettype none
module tcc_prescale (
    input  wire       CLK,   // system clock
    input  wire       NRST,  // async reset, active low
    output wire [3:0] TICK   // [k] pulses once per 2**k clocks
);
    reg [2:0] div;  // divider chain

    // ---------------------------------------------------------------
    // divider
    // ---------------------------------------------------------------
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            div <= 3'h0;
        end else begin
            div <= div + 3'h1;
        end
    end

    // tick on the carry of each stage
    assign TICK = {&div[2:0], &div[1:0], div[0], 1'b1};
endmodule // tcc_prescale
`default_nettype wire

// file: rtl/tcc_timer.v
// three-channel 16-bit capture/compare timer with ahb-lite register access
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defs.vh"
// Contract
// R1: counter clock is phi, phi/2, phi/4, phi/8
// R2: external clock counts rising, falling or both
// R3: source holds external pulses 1.5/2.5 clocks
// R4: match sets 0/1/toggle; channel 2 no toggle
// R5: level already held leaves pin unchanged
// R6: match acts when counter leaves matching value
// R7: selected pin edge captures counter into register
// R8: source holds capture pulses 1.5/2.5 clocks
// R9: clear on match or capture of A/B
// R10: counter write reaches all synchronized counters
// R11: sync-clear channel clears with synchronized peer
// R12: pwm: match A sets 1, B sets 0
// R13: pwm: equal registers leave pin unchanged
// R14: pwm clear on B, A>B gives 0%
// R15: pwm clear on A, B>A gives 100%
// R16: pwm forces A pin output, free/sync ok
// R17: phase counting only in channel 2, up/down
// R18: phase mode ignores source and edge select
// R19: phase mode keeps clear, io, flags, start, registers
// R20: phase mode acts on every quadrature edge
// R21: quadrature source keeps 1.5/2.5 state timing
// R22: down/up decided by edge and other level
// R23: counter halted until run bit; free-running default
// R24: wrap sets overflow flag, counting continues
// R25: match sets flag, optionally clears counter
module tcc_timer (
    input  wire        CLK,                  // system clock, 50 MHz
    input  wire        NRST,                 // async reset, active low
    input  wire        HSEL,                 // ahb-lite slave select
    input  wire [7:0]  HADDR,                // byte address
    input  wire [1:0]  HTRANS,               // transfer type
    input  wire        HWRITE,               // write strobe
    input  wire [2:0]  HSIZE,                // word only
    input  wire [31:0] HWDATA,               // write data
    input  wire        HREADY,               // bus ready
    output reg  [31:0] HRDATA,               // read data
    output reg         HREADYOUT,            // always ready
    output reg         HRESP,                // always okay
    input  wire        EXT_CLOCK_IN_FIRST,   // external clock a / quadrature a
    input  wire        EXT_CLOCK_IN_SECOND,  // external clock b / quadrature b
    input  wire        EXT_CLOCK_IN_THIRD,   // external clock c
    input  wire        EXT_CLOCK_IN_FOURTH,  // external clock d
    input  wire [2:0]  CC_PIN_FIRST_IN,      // capture/compare pin a, input
    output reg  [2:0]  CC_PIN_FIRST_OUT,     // pin a, output level
    output reg  [2:0]  CC_PIN_FIRST_OE_N,    // pin a, low while driven
    input  wire [2:0]  CC_PIN_SECOND_IN,     // capture/compare pin b, input
    output reg  [2:0]  CC_PIN_SECOND_OUT,    // pin b, output level
    output reg  [2:0]  CC_PIN_SECOND_OE_N    // pin b, low while driven
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg [`TCC_CTRL_W-1:0] channel_control [0:2];  // per-channel setup
    reg [6:0]  pin_function_control [0:2];        // io codes a and b
    reg [15:0] channel_counter [0:2];             // counters
    reg [15:0] general_register_first [0:2];      // compare/capture a
    reg [15:0] general_register_second [0:2];     // compare/capture b
    reg [2:0]  flags [0:2];                       // match a, match b, overflow
    reg [2:0]  start_register;                    // run bits
    reg        dp_wr;                             // data phase is a write
    reg [7:0]  dp_addr;                           // data phase address

    // ---------------------------------------------------------------
    // edge sources
    // ---------------------------------------------------------------
    wire [3:0] pre_tick;  // internal count ticks
    wire [3:0] ext_r;     // external clock rising
    wire [3:0] ext_f;     // external clock falling
    wire [3:0] ext_l;     // external clock prior level
    wire [2:0] pa_r;      // pin a rising
    wire [2:0] pa_f;      // pin a falling
    wire [2:0] pb_r;      // pin b rising
    wire [2:0] pb_f;      // pin b falling

    tcc_prescale u_pre (
        .CLK  (CLK),
        .NRST (NRST),
        .TICK (pre_tick)
    );

    tcc_edge #(.W(4)) u_ext (
        .CLK  (CLK),
        .NRST (NRST),
        .PIN  ({EXT_CLOCK_IN_FOURTH, EXT_CLOCK_IN_THIRD, EXT_CLOCK_IN_SECOND, EXT_CLOCK_IN_FIRST}),
        .RISE (ext_r),
        .FALL (ext_f),
        .LVL  (ext_l)
    );

    tcc_edge #(.W(3)) u_pa (
        .CLK  (CLK),
        .NRST (NRST),
        .PIN  (CC_PIN_FIRST_IN),
        .RISE (pa_r),
        .FALL (pa_f),
        .LVL  ()
    );

    tcc_edge #(.W(3)) u_pb (
        .CLK  (CLK),
        .NRST (NRST),
        .PIN  (CC_PIN_SECOND_IN),
        .RISE (pb_r),
        .FALL (pb_f),
        .LVL  ()
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // pick edge: both, else falling, else rising
    function pick_edge;
        input r;
        input f;
        input both;
        input fall;
        begin
            pick_edge = both ? (r | f) : (fall ? f : r);
        end
    endfunction

    // byte address of a channel register
    function [7:0] reg_addr;
        input [1:0] ch;
        input [7:0] ofs;
        begin
            reg_addr = ({6'h00, ch} * `TCC_CH_STRIDE) + ofs;
        end
    endfunction

    // ---------------------------------------------------------------
    // per-channel event decode
    // ---------------------------------------------------------------
    reg [2:0] tick;      // counter advances
    reg [2:0] down;      // count direction
    reg [2:0] cm_a;      // compare match a
    reg [2:0] cm_b;      // compare match b
    reg [2:0] cap_a;     // capture a
    reg [2:0] cap_b;     // capture b
    reg [2:0] clr_own;   // own clear event
    reg [2:0] clr;       // final clear
    reg [2:0] sync_clr;  // any synchronized channel clears
    reg [2:0] cnt_wr;    // counter written
    reg [2:0] src;       // selected source edge
    reg [2:0] phase;     // phase mode active
    integer   c;

    always @* begin
        tick     = 3'h0;
        down     = 3'h0;
        cm_a     = 3'h0;
        cm_b     = 3'h0;
        cap_a    = 3'h0;
        cap_b    = 3'h0;
        clr_own  = 3'h0;
        clr      = 3'h0;
        sync_clr = 3'h0;
        cnt_wr   = 3'h0;
        src      = 3'h0;
        phase    = 3'h0;
        for (c = 0; c < 3; c = c + 1) begin
            // source selection: internal prescale or external edge
            if (!channel_control[c][`TCC_CS_LSB+2]) begin
                src[c] = pre_tick[channel_control[c][`TCC_CS_LSB +: 2]]; // R1
            end else begin
                src[c] = pick_edge(ext_r[channel_control[c][`TCC_CS_LSB +: 2]],
                                   ext_f[channel_control[c][`TCC_CS_LSB +: 2]],
                                   channel_control[c][`TCC_EDGE_HIGH],
                                   channel_control[c][`TCC_EDGE_LOW]); // R2
            end
            phase[c] = (c == 2) && channel_control[c][`TCC_PHASE_BIT]; // R17
            if (phase[c]) begin
                // every edge of both quadrature inputs counts
                src[c]  = ext_r[0] | ext_f[0] | ext_r[1] | ext_f[1]; // R18 R20
                down[c] = (ext_r[1] & ~ext_l[0]) | (ext_r[0] & ext_l[1]) |
                          (ext_f[1] & ext_l[0]) | (ext_f[0] & ~ext_l[1]); // R22
            end
            tick[c] = start_register[c] & src[c]; // R23
            // match flagged on the tick that leaves the matching value
            cm_a[c] = tick[c] && (channel_counter[c] == general_register_first[c]) &&
                      (channel_control[c][`TCC_PWM_BIT] || !pin_function_control[c][2]); // R6 R16
            cm_b[c] = tick[c] && (channel_counter[c] == general_register_second[c]) &&
                      (channel_control[c][`TCC_PWM_BIT] || !pin_function_control[c][`TCC_PIN_B_LSB+2]);
            // capture on the selected pin edge, input mode only
            cap_a[c] = !channel_control[c][`TCC_PWM_BIT] && pin_function_control[c][2] &&
                       pick_edge(pa_r[c], pa_f[c], pin_function_control[c][1],
                                 pin_function_control[c][0]); // R7 R19
            cap_b[c] = !channel_control[c][`TCC_PWM_BIT] && pin_function_control[c][`TCC_PIN_B_LSB+2] &&
                       pick_edge(pb_r[c], pb_f[c], pin_function_control[c][`TCC_PIN_B_LSB+1],
                                 pin_function_control[c][`TCC_PIN_B_LSB]); // R7
            case (channel_control[c][`TCC_CLR_LSB +: 2])
                `TCC_CLR_ON_A: clr_own[c] = cm_a[c] | cap_a[c]; // R9 R25
                `TCC_CLR_ON_B: clr_own[c] = cm_b[c] | cap_b[c]; // R9 R25
                default:       clr_own[c] = 1'b0;
            endcase
            cnt_wr[c] = dp_wr && (dp_addr == reg_addr(c[1:0], `TCC_OFS_CNT));
        end
        for (c = 0; c < 3; c = c + 1) begin
            sync_clr[c] = |(clr_own & {channel_control[2][`TCC_SYNC_BIT],
                                       channel_control[1][`TCC_SYNC_BIT],
                                       channel_control[0][`TCC_SYNC_BIT]});
            clr[c] = clr_own[c] | (channel_control[c][`TCC_SYNC_BIT] && sync_clr[c] &&
                     (channel_control[c][`TCC_CLR_LSB +: 2] == `TCC_CLR_SYNC)); // R11
        end
    end

    // any write to a synchronized channel's counter presets every synchronized channel
    wire sync_wr = |(cnt_wr & {channel_control[2][`TCC_SYNC_BIT],
                               channel_control[1][`TCC_SYNC_BIT],
                               channel_control[0][`TCC_SYNC_BIT]});

    // ---------------------------------------------------------------
    // counters, registers, flags and pins
    // ---------------------------------------------------------------
    integer i;

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            for (i = 0; i < 3; i = i + 1) begin
                channel_control[i]         <= `TCC_CTRL_RST;
                pin_function_control[i]    <= `TCC_PINCTL_RST;
                channel_counter[i]         <= `TCC_CNT_ZERO;
                general_register_first[i]  <= `TCC_GR_RST;
                general_register_second[i] <= `TCC_GR_RST;
                flags[i]                   <= 3'h0;
            end
            start_register     <= 3'h0;
            CC_PIN_FIRST_OUT   <= 3'h0;
            CC_PIN_FIRST_OE_N  <= 3'h7;
            CC_PIN_SECOND_OUT  <= 3'h0;
            CC_PIN_SECOND_OE_N <= 3'h7;
        end else begin
            if (dp_wr && dp_addr == `TCC_OFS_START) begin
                start_register <= HWDATA[2:0];
            end
            for (i = 0; i < 3; i = i + 1) begin
                // setup writes
                if (dp_wr && dp_addr == reg_addr(i[1:0], `TCC_OFS_CTRL)) begin
                    channel_control[i] <= HWDATA[`TCC_CTRL_W-1:0];
                end
                if (dp_wr && dp_addr == reg_addr(i[1:0], `TCC_OFS_PINCTL)) begin
                    pin_function_control[i] <= HWDATA[6:0];
                end
                // counter: clear beats write, write beats count
                if (clr[i]) begin
                    channel_counter[i] <= `TCC_CNT_ZERO; // R9 R25
                end else if (cnt_wr[i] || (sync_wr && channel_control[i][`TCC_SYNC_BIT])) begin
                    channel_counter[i] <= HWDATA[15:0]; // R10
                end else if (tick[i]) begin
                    channel_counter[i] <= down[i] ? channel_counter[i] - 16'h0001
                                                  : channel_counter[i] + 16'h0001; // R24
                end
                // general registers: capture beats write
                if (cap_a[i]) begin
                    general_register_first[i] <= channel_counter[i]; // R7
                end else if (dp_wr && dp_addr == reg_addr(i[1:0], `TCC_OFS_GRA)) begin
                    general_register_first[i] <= HWDATA[15:0];
                end
                if (cap_b[i]) begin
                    general_register_second[i] <= channel_counter[i]; // R7
                end else if (dp_wr && dp_addr == reg_addr(i[1:0], `TCC_OFS_GRB)) begin
                    general_register_second[i] <= HWDATA[15:0];
                end
                // flags: write 0 clears, a new event wins
                flags[i] <= ((dp_wr && dp_addr == reg_addr(i[1:0], `TCC_OFS_FLAGS))
                             ? (flags[i] & HWDATA[2:0]) : flags[i]) |
                            {tick[i] && (down[i] ? channel_counter[i] == `TCC_CNT_ZERO
                                                 : channel_counter[i] == `TCC_CNT_MAX),
                             cm_b[i] | cap_b[i], cm_a[i] | cap_a[i]}; // R24 R25
                // pin a
                if (channel_control[i][`TCC_PWM_BIT]) begin
                    CC_PIN_FIRST_OE_N[i] <= 1'b0; // R16
                    if (cm_a[i] && cm_b[i]) begin
                        CC_PIN_FIRST_OUT[i] <= CC_PIN_FIRST_OUT[i]; // R13
                    end else if (cm_b[i]) begin
                        CC_PIN_FIRST_OUT[i] <= 1'b0; // R12 R14
                    end else if (cm_a[i]) begin
                        CC_PIN_FIRST_OUT[i] <= 1'b1; // R12 R15
                    end
                end else begin
                    CC_PIN_FIRST_OE_N[i] <= pin_function_control[i][2] ||
                                            pin_function_control[i][2:0] == `TCC_IO_NONE;
                    if (cm_a[i]) begin
                        case (pin_function_control[i][2:0])
                            `TCC_IO_OUT0:   CC_PIN_FIRST_OUT[i] <= 1'b0; // R4 R5
                            `TCC_IO_OUT1:   CC_PIN_FIRST_OUT[i] <= 1'b1; // R4 R5
                            `TCC_IO_TOGGLE: CC_PIN_FIRST_OUT[i] <= (i == 2) ? CC_PIN_FIRST_OUT[i]
                                                                            : ~CC_PIN_FIRST_OUT[i]; // R4
                            default:        CC_PIN_FIRST_OUT[i] <= CC_PIN_FIRST_OUT[i];
                        endcase
                    end
                end
                // pin b
                CC_PIN_SECOND_OE_N[i] <= channel_control[i][`TCC_PWM_BIT] ||
                                         pin_function_control[i][`TCC_PIN_B_LSB+2] ||
                                         pin_function_control[i][`TCC_PIN_B_LSB +: 3] == `TCC_IO_NONE;
                if (cm_b[i] && !channel_control[i][`TCC_PWM_BIT]) begin
                    case (pin_function_control[i][`TCC_PIN_B_LSB +: 3])
                        `TCC_IO_OUT0:   CC_PIN_SECOND_OUT[i] <= 1'b0; // R4 R5
                        `TCC_IO_OUT1:   CC_PIN_SECOND_OUT[i] <= 1'b1; // R4 R5
                        `TCC_IO_TOGGLE: CC_PIN_SECOND_OUT[i] <= (i == 2) ? CC_PIN_SECOND_OUT[i]
                                                                         : ~CC_PIN_SECOND_OUT[i]; // R4
                        default:        CC_PIN_SECOND_OUT[i] <= CC_PIN_SECOND_OUT[i];
                    endcase
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // ahb-lite slave: zero wait, registered read data
    // ---------------------------------------------------------------
    wire acc = HSEL && HREADY && HTRANS[1];  // accepted address phase

    // read mux on the address phase address
    reg [31:0] rd;
    integer    k;
    always @* begin
        rd = 32'h00000000;
        if (HADDR == `TCC_OFS_START) begin
            rd = {29'h00000000, start_register};
        end
        for (k = 0; k < 3; k = k + 1) begin
            if (HADDR == reg_addr(k[1:0], `TCC_OFS_CTRL)) begin
                rd = {22'h000000, channel_control[k]};
            end
            if (HADDR == reg_addr(k[1:0], `TCC_OFS_PINCTL)) begin
                rd = {25'h0000000, pin_function_control[k]};
            end
            if (HADDR == reg_addr(k[1:0], `TCC_OFS_CNT)) begin
                rd = {16'h0000, channel_counter[k]};
            end
            if (HADDR == reg_addr(k[1:0], `TCC_OFS_GRA)) begin
                rd = {16'h0000, general_register_first[k]};
            end
            if (HADDR == reg_addr(k[1:0], `TCC_OFS_GRB)) begin
                rd = {16'h0000, general_register_second[k]};
            end
            if (HADDR == reg_addr(k[1:0], `TCC_OFS_FLAGS)) begin
                rd = {29'h00000000, flags[k]};
            end
        end
    end

    // address phase capture and response
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            dp_wr     <= 1'b0;
            dp_addr   <= 8'h00;
            HRDATA    <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            dp_wr     <= acc && HWRITE;
            if (acc) begin
                dp_addr <= HADDR;
            end
            if (acc && !HWRITE) begin
                HRDATA <= rd;
            end
        end
    end
endmodule // tcc_timer
`default_nettype wire

// file: testbench/tcc_encoder.sv
// quadrature encoder model on the two external clock inputs
`timescale 1ns/100ps
`default_nettype none
module tcc_encoder (
    input  wire logic CLK,
    input  wire logic STEP,  // one quarter phase
    input  wire logic DIR,   // 1: a leads b
    output wire logic QA,
    output wire logic QB
);
    logic [1:0] ph = 2'h0;  // quarter-phase index
    // one edge per request, bench spaces them 4 clocks
    always @(posedge CLK) if (STEP) ph <= DIR ? ph + 2'h1 : ph - 2'h1;
    assign QA = ph[0] ^ ph[1];
    assign QB = ph[1];
endmodule // tcc_encoder
`default_nettype wire

// file: testbench/tcc_timer_sva.sv
// bus and pin checker for the timer
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_sva (
    input wire logic        CLK, NRST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP,
    input wire logic [7:0]  HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic [31:0] HRDATA,
    input wire logic [2:0]  CC_PIN_FIRST_OUT, CC_PIN_FIRST_OE_N, CC_PIN_SECOND_OUT, CC_PIN_SECOND_OE_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    wire rd = HSEL && HREADY && HTRANS[1] && !HWRITE;  // read taken
    property p_rdy; HREADYOUT; endproperty
    a_rdy: assert property (p_rdy) else $error("bus stalled");
    property p_resp; !HRESP; endproperty
    a_resp: assert property (p_resp) else $error("error response");
    property p_unmap; rd && HADDR == 8'h7C |=> HRDATA == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold; !rd |=> $stable(HRDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_oea; ((CC_PIN_FIRST_OUT ^ $past(CC_PIN_FIRST_OUT)) & CC_PIN_FIRST_OE_N & $past(CC_PIN_FIRST_OE_N)) == 3'h0; endproperty
    a_oea: assert property (p_oea) else $error("undriven pin a moved");
    property p_oeb; ((CC_PIN_SECOND_OUT ^ $past(CC_PIN_SECOND_OUT)) & CC_PIN_SECOND_OE_N & $past(CC_PIN_SECOND_OE_N)) == 3'h0; endproperty
    a_oeb: assert property (p_oeb) else $error("undriven pin b moved");
    property p_rst; $rose(NRST) |-> CC_PIN_FIRST_OE_N == 3'h7 && CC_PIN_SECOND_OE_N == 3'h7; endproperty
    a_rst: assert property (p_rst) else $error("pins driven after reset");
    property p_rstout; $rose(NRST) |-> CC_PIN_FIRST_OUT == 3'h0 ##1 CC_PIN_FIRST_OUT == 3'h0; endproperty
    a_rstout: assert property (p_rstout) else $error("pin level after reset");
    c_rd: cover property (rd);
    c_up: cover property ($rose(CC_PIN_FIRST_OUT[0]));
    c_pwm: cover property ($fell(CC_PIN_FIRST_OE_N[1]));
endmodule // tcc_timer_sva
bind tcc_timer tcc_timer_sva chk_u (.CLK, .NRST, .HSEL, .HWRITE, .HREADY, .HREADYOUT, .HRESP, .HADDR, .HTRANS,
    .HRDATA, .CC_PIN_FIRST_OUT, .CC_PIN_FIRST_OE_N, .CC_PIN_SECOND_OUT, .CC_PIN_SECOND_OE_N);
`default_nettype wire

// file: testbench/tcc_timer_tb.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_tb;
    logic CLK = 0, NRST = 0, HSEL = 0, HWRITE = 0, step = 0, dir = 0;
    logic [7:0] HADDR = 8'h0;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HWDATA = 32'h0;
    wire [31:0] HRDATA;
    wire [2:0] pa, pa_oe_n;
    wire HREADYOUT, HRESP, qa, qb;
    int num_errors = 0, compares = 0;
    always #10 CLK = ~CLK;
    tcc_encoder enc_u (.CLK, .STEP(step), .DIR(dir), .QA(qa), .QB(qb));
    tcc_timer dut_u (.CLK, .NRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT),
        .HRDATA, .HREADYOUT, .HRESP, .EXT_CLOCK_IN_FIRST(qa), .EXT_CLOCK_IN_SECOND(qb), .EXT_CLOCK_IN_THIRD(1'b0),
        .EXT_CLOCK_IN_FOURTH(1'b0), .CC_PIN_FIRST_IN({2'h0, qa}), .CC_PIN_FIRST_OUT(pa), .CC_PIN_FIRST_OE_N(pa_oe_n),
        .CC_PIN_SECOND_IN(3'h0), .CC_PIN_SECOND_OUT(), .CC_PIN_SECOND_OE_N());
    task automatic chk(input [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one ahb-lite single word transfer
    task automatic bus(input w, input [7:0] a, input [31:0] d, output [31:0] r);
        @(posedge CLK);
        HSEL <= 1'b1; HTRANS <= 2'h2; HADDR <= a; HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        r = HRDATA;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdc(input [7:0] a, input [31:0] m, exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r & m, exp);
    endtask
    // cycles until pin a of channel b changes
    task automatic gap(input int b, output int n);
        logic v;
        v = pa[b];
        n = 0;
        do begin @(posedge CLK); n++; end while (pa[b] === v && n < 50);
    endtask
    task automatic hold(input int b, input logic e, input int n);
        repeat (n) begin @(posedge CLK); chk(pa[b], e); end
    endtask
    task automatic qstep(input logic d, input int n);
        repeat (n) begin
            step <= 1'b1; dir <= d;
            @(posedge CLK);
            step <= 1'b0;
            repeat (3) @(posedge CLK);
        end
    endtask
    // periodic toggle on ch0, toggle code on ch2 does nothing
    task automatic t_period;
        int n;
        rdc(8'h0C, 32'hFFFF, 32'hFFFF);
        rdc(8'h7C, 32'hFFFFFFFF, 32'h0);
        wr(8'h00, 32'h20); wr(8'h0C, 32'h3); wr(8'h04, 32'h3);
        wr(8'h40, 32'h20); wr(8'h4C, 32'h3); wr(8'h44, 32'h3);
        wr(8'h60, 32'h5);
        gap(0, n); gap(0, n);
        chk(n, 4);
        hold(2, 1'b0, 12);
        rdc(8'h14, 32'h1, 32'h1);
    endtask
    // pwm at 0% then 100% on ch1
    task automatic t_pwm;
        wr(8'h60, 32'h0);
        wr(8'h20, 32'hC0); wr(8'h2C, 32'h8); wr(8'h30, 32'h4); wr(8'h60, 32'h2);
        hold(1, 1'b0, 20);
        chk(pa_oe_n[1], 1'b0);
        wr(8'h60, 32'h0); wr(8'h28, 32'h0);
        wr(8'h20, 32'hA0); wr(8'h2C, 32'h4); wr(8'h30, 32'h8); wr(8'h60, 32'h2);
        repeat (10) @(posedge CLK);
        hold(1, 1'b1, 20);
    endtask
    // ch2 up/down count from the encoder, underflow flag
    task automatic t_phase;
        wr(8'h60, 32'h0);
        wr(8'h04, 32'h5); wr(8'h08, 32'h5);  // ch0 captures on falling encoder a, clears on A
        wr(8'h40, 32'h200); wr(8'h48, 32'h0); wr(8'h54, 32'h0); wr(8'h60, 32'h4);
        qstep(1'b1, 6);
        rdc(8'h48, 32'hFFFF, 32'h6);
        rdc(8'h0C, 32'hFFFF, 32'h5);
        rdc(8'h08, 32'hFFFF, 32'h0);
        qstep(1'b0, 8);
        rdc(8'h48, 32'hFFFF, 32'hFFFE);
        rdc(8'h54, 32'h4, 32'h4);
    endtask
    task automatic summarize;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge CLK);
        NRST <= 1'b1;
        t_period; t_pwm; t_phase;
        summarize;
    end
    initial begin
        #200000;
        num_errors++;
        summarize;
    end
endmodule // tcc_timer_tb
`default_nettype wire
